// ---- rtl/rivm_pkg.sv ----
// Package: vector addresses, request layout and shared types
package rivm_pkg;

    localparam int ADDR_W = 15;
    localparam int NUM_SRC = 25;

    // Reset target and vector table base with relocation off
    localparam logic [14:0] RESET_ADDR = 15'h0000;
    localparam logic [14:0] TABLE_BASE = 15'h0002;
    // Each vector slot is two program words
    localparam logic [14:0] SLOT_STEP = 15'h0002;
    // Boot-reset fuse value that means unprogrammed
    localparam logic BOOT_FUSE_UNPROG = 1'h1;
    // Default boot section starts, one per boot-size fuse code
    localparam logic [14:0] BOOT_START_0 = 15'h3800;
    localparam logic [14:0] BOOT_START_1 = 15'h3c00;
    localparam logic [14:0] BOOT_START_2 = 15'h3e00;
    localparam logic [14:0] BOOT_START_3 = 15'h3f00;

    // Request bit positions, lowest vector number in bit 0
    localparam int EXT_IRQ_ZERO = 0;
    localparam int EXT_IRQ_ONE = 1;
    localparam int PIN_CHANGE_REQ_ZERO = 2;
    localparam int PIN_CHANGE_REQ_ONE = 3;
    localparam int PIN_CHANGE_REQ_TWO = 4;
    localparam int WATCHDOG_TIMEOUT_REQ = 5;
    localparam int T2_MATCH_A_REQ = 6;
    localparam int T2_MATCH_B_REQ = 7;
    localparam int T2_OVERFLOW_REQ = 8;
    localparam int T1_CAPTURE_REQ = 9;
    localparam int T1_MATCH_A_REQ = 10;
    localparam int T1_MATCH_B_REQ = 11;
    localparam int T1_OVERFLOW_REQ = 12;
    localparam int T0_MATCH_A_REQ = 13;
    localparam int T0_MATCH_B_REQ = 14;
    localparam int T0_OVERFLOW_REQ = 15;
    localparam int SPI_DONE_REQ = 16;
    localparam int UART_RX_DONE_REQ = 17;
    localparam int UART_TX_EMPTY_REQ = 18;
    localparam int UART_TX_DONE_REQ = 19;
    localparam int ADC_DONE_REQ = 20;
    localparam int EEPROM_READY_REQ = 21;
    localparam int ANALOG_CMP_REQ = 22;
    localparam int TWO_WIRE_REQ = 23;
    localparam int SELF_PROGRAM_READY_REQ = 24;

    typedef enum logic [1:0] {
        RIVM_IDLE = 2'h0,
        RIVM_SERVE = 2'h1,
        RIVM_RESET = 2'h3
    } rivm_phase_type;

    // Answer to the core: fetch target and its kind
    typedef struct packed {
        logic valid;
        logic is_reset;
        logic [4:0] vector_num;
        logic [14:0] addr;
    } rivm_fetch_type;

    typedef struct packed {
        rivm_phase_type phase;
        rivm_fetch_type fetch;
    } rivm_state_type;

endpackage

// ---- rtl/rivm_prio_enc.sv ----
// Lowest-index priority encoder over pending requests
`timescale 1ns/1ps
module rivm_prio_enc #(
    parameter int WIDTH = 25,
    parameter int IDX_W = 5
) (
    input wire logic [WIDTH-1:0] req,
    output logic any,
    output logic [IDX_W-1:0] index
);
    always_comb begin
        any = 1'b0;
        index = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                index = IDX_W'(i);
            end
        end
    end
endmodule // rivm_prio_enc

// ---- rtl/rivm_vector_map.sv ----
// Reset and interrupt vector address map with boot relocation
//
// Behaviour
// (R1) With the boot-reset fuse unprogrammed, a system reset targets vector one at program address 0x0000.
// (R2) External requests zero and one vector to 0x0002 and 0x0004.
// (R3) Pin-change requests use 0x0006..0x000A; watchdog time-out uses 0x000C.
// (R4) Timer two match A, match B, overflow vector to 0x000E, 0x0010, 0x0012.
// (R5) Timer one capture, match A, match B, overflow use 0x0014..0x001A.
// (R6) Timer zero match A, match B, overflow use 0x001C..0x0020.
// (R7) Serial peripheral transfer complete vectors to 0x0022.
// (R8) UART receive, data empty, transmit done use 0x0024, 0x0026, 0x0028.
// (R9) ADC, EEPROM, comparator, two-wire, self-program use 0x002A..0x0032.
// (R10) Programmed boot-reset fuse sends every reset to the boot start.
// (R11) Vector-select set adds the boot section start to each interrupt vector.
// (R12) Fuse 1 means unprogrammed; reset and table relocate independently.
// (R13) Software may put code in slots whose vectors are never used.
// (R14) Boot section start comes from the boot-size fuse setting.
// (R15) Among pending enabled requests the lowest vector number goes first.
`timescale 1ns/1ps
module rivm_vector_map #(
    parameter logic [14:0] BOOT_START_0 = rivm_pkg::BOOT_START_0,
    parameter logic [14:0] BOOT_START_1 = rivm_pkg::BOOT_START_1,
    parameter logic [14:0] BOOT_START_2 = rivm_pkg::BOOT_START_2,
    parameter logic [14:0] BOOT_START_3 = rivm_pkg::BOOT_START_3
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic boot_reset_fuse,
    input wire logic [1:0] boot_size_fuses,
    input wire logic vector_select_bit,
    input wire logic [rivm_pkg::NUM_SRC-1:0] irq_req,
    input wire logic [rivm_pkg::NUM_SRC-1:0] irq_enable,
    input wire logic global_irq_enable,
    input wire logic fetch_ready,
    output rivm_pkg::rivm_fetch_type fetch,
    output logic [rivm_pkg::NUM_SRC-1:0] irq_ack
);

    // ------------------------------------------------------------
    // Working signals
    // ------------------------------------------------------------
    rivm_pkg::rivm_state_type state;
    rivm_pkg::rivm_state_type next_state;
    logic [14:0] boot_start;
    logic [14:0] table_base;
    logic [14:0] reset_target;
    logic [rivm_pkg::NUM_SRC-1:0] pending;
    logic pend_any;
    logic [4:0] pend_index;
    logic [4:0] vec_num;
    logic [14:0] slot_offset;
    logic [14:0] vec_addr;
    logic [rivm_pkg::NUM_SRC-1:0] grant;

    // ------------------------------------------------------------
    // Boot section start
    // ------------------------------------------------------------
    always_comb begin
        unique case (boot_size_fuses) // R14
            2'h0: boot_start = BOOT_START_0;
            2'h1: boot_start = BOOT_START_1;
            2'h2: boot_start = BOOT_START_2;
            2'h3: boot_start = BOOT_START_3;
        endcase
    end

    // ------------------------------------------------------------
    // Reset target and table placement
    // ------------------------------------------------------------
    // The fuse moves only the reset target and the select bit only
    // the table, so a boot loader may keep either one in place.
    always_comb begin
        if (boot_reset_fuse == rivm_pkg::BOOT_FUSE_UNPROG) begin
            reset_target = rivm_pkg::RESET_ADDR; // R1 R12
        end else begin
            reset_target = boot_start; // R10
        end
    end

    always_comb begin
        if (vector_select_bit) begin
            table_base = 15'(boot_start + rivm_pkg::TABLE_BASE); // R11
        end else begin
            table_base = rivm_pkg::TABLE_BASE; // R12
        end
    end

    // ------------------------------------------------------------
    // Request selection
    // ------------------------------------------------------------
    // A request counts only while its own and the global enable are set
    assign pending = global_irq_enable ? (irq_req & irq_enable) : '0;

    // Bit order is vector order, so the lowest set bit goes first
    rivm_prio_enc #(
        .WIDTH(rivm_pkg::NUM_SRC),
        .IDX_W(5)
    ) rivm_prio_enc_inst (
        .req(pending),
        .any(pend_any),
        .index(pend_index)
    ); // R15

    // One-hot acknowledge for the source that wins, zero when none
    assign grant = {{(rivm_pkg::NUM_SRC-1){1'b0}}, pend_any} << pend_index;

    // ------------------------------------------------------------
    // Vector slot table
    // ------------------------------------------------------------
    // Vector number of each source; encoder codes past the last source
    // cannot occur and fall back to the first interrupt vector.
    always_comb begin
        vec_num = 5'h02;
        unique case (pend_index)
            // External requests
            5'(rivm_pkg::EXT_IRQ_ZERO): vec_num = 5'h02; // R2
            5'(rivm_pkg::EXT_IRQ_ONE): vec_num = 5'h03; // R2
            // Pin change and watchdog time-out
            5'(rivm_pkg::PIN_CHANGE_REQ_ZERO): vec_num = 5'h04; // R3
            5'(rivm_pkg::PIN_CHANGE_REQ_ONE): vec_num = 5'h05; // R3
            5'(rivm_pkg::PIN_CHANGE_REQ_TWO): vec_num = 5'h06; // R3
            5'(rivm_pkg::WATCHDOG_TIMEOUT_REQ): vec_num = 5'h07; // R3
            // Timer two
            5'(rivm_pkg::T2_MATCH_A_REQ): vec_num = 5'h08; // R4
            5'(rivm_pkg::T2_MATCH_B_REQ): vec_num = 5'h09; // R4
            5'(rivm_pkg::T2_OVERFLOW_REQ): vec_num = 5'h0a; // R4
            // Timer one
            5'(rivm_pkg::T1_CAPTURE_REQ): vec_num = 5'h0b; // R5
            5'(rivm_pkg::T1_MATCH_A_REQ): vec_num = 5'h0c; // R5
            5'(rivm_pkg::T1_MATCH_B_REQ): vec_num = 5'h0d; // R5
            5'(rivm_pkg::T1_OVERFLOW_REQ): vec_num = 5'h0e; // R5
            // Timer zero
            5'(rivm_pkg::T0_MATCH_A_REQ): vec_num = 5'h0f; // R6
            5'(rivm_pkg::T0_MATCH_B_REQ): vec_num = 5'h10; // R6
            5'(rivm_pkg::T0_OVERFLOW_REQ): vec_num = 5'h11; // R6
            // Serial peripheral and UART
            5'(rivm_pkg::SPI_DONE_REQ): vec_num = 5'h12; // R7
            5'(rivm_pkg::UART_RX_DONE_REQ): vec_num = 5'h13; // R8
            5'(rivm_pkg::UART_TX_EMPTY_REQ): vec_num = 5'h14; // R8
            5'(rivm_pkg::UART_TX_DONE_REQ): vec_num = 5'h15; // R8
            // Converter, memory, comparator, two-wire, self-program
            5'(rivm_pkg::ADC_DONE_REQ): vec_num = 5'h16; // R9
            5'(rivm_pkg::EEPROM_READY_REQ): vec_num = 5'h17; // R9
            5'(rivm_pkg::ANALOG_CMP_REQ): vec_num = 5'h18; // R9
            5'(rivm_pkg::TWO_WIRE_REQ): vec_num = 5'h19; // R9
            5'(rivm_pkg::SELF_PROGRAM_READY_REQ): vec_num = 5'h1a; // R9
            default: vec_num = 5'h02;
        endcase
    end

    // ------------------------------------------------------------
    // Vector address
    // ------------------------------------------------------------
    // Two program words per slot, counted from the table base; moving
    // the table keeps the slot spacing unchanged.
    assign slot_offset = 15'(vec_num - 5'h02) * rivm_pkg::SLOT_STEP;
    assign vec_addr = 15'(table_base + slot_offset); // R11

    // ------------------------------------------------------------
    // Dispatch sequencing
    // ------------------------------------------------------------
    // One answer at a time: a request is taken only from idle, so the
    // core never sees the target change while it holds one.
    always_comb begin
        next_state = state;
        irq_ack = '0;
        unique case (state.phase)
            rivm_pkg::RIVM_RESET: begin
                // First answer after any reset is the reset target
                next_state.fetch.valid = 1'b1;
                next_state.fetch.is_reset = 1'b1;
                next_state.fetch.vector_num = 5'h01;
                next_state.fetch.addr = reset_target; // R1 R10
                next_state.phase = rivm_pkg::RIVM_SERVE;
            end
            rivm_pkg::RIVM_IDLE: begin
                if (pend_any) begin
                    next_state.fetch.valid = 1'b1;
                    next_state.fetch.is_reset = 1'b0;
                    next_state.fetch.vector_num = vec_num;
                    next_state.fetch.addr = vec_addr;
                    next_state.phase = rivm_pkg::RIVM_SERVE;
                    irq_ack = grant; // R15
                end
            end
            rivm_pkg::RIVM_SERVE: begin
                // Hold the answer until the core takes it
                if (fetch_ready) begin
                    next_state.fetch.valid = 1'b0;
                    next_state.phase = rivm_pkg::RIVM_IDLE;
                end
            end
            default: begin
                // Unused phase code: drop back to idle with no answer
                next_state.phase = rivm_pkg::RIVM_IDLE;
                next_state.fetch.valid = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Every system reset source arrives on one line; the answer after
    // release is always the reset target, ahead of any request.
    always_ff @(posedge clock) begin
        if (rst) begin
            state.phase <= rivm_pkg::RIVM_RESET;
            state.fetch <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // The core sees only registered fetch fields
    assign fetch = state.fetch;

endmodule // rivm_vector_map

// ---- testbench/rivm_core_model.sv ----
// Partner model: core that takes fetch targets after a set stall
`timescale 1ns/1ps
module rivm_core_model (
    input wire logic clock,
    input wire logic rst,
    input rivm_pkg::rivm_fetch_type fetch,
    input wire logic [3:0] stall,
    output logic fetch_ready
);
    logic [3:0] waited;
    always_ff @(posedge clock) begin
        if (rst || !fetch.valid) begin
            waited <= 4'h0;
        end else if (!fetch_ready) begin
            waited <= waited + 4'h1;
        end
    end
    assign fetch_ready = fetch.valid && waited >= stall;
endmodule // rivm_core_model

// ---- testbench/rivm_vector_map_sva.sv ----
// Checker: port assertions for the vector map
`timescale 1ns/1ps
module rivm_vector_map_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic boot_reset_fuse,
    input wire logic vector_select_bit,
    input wire logic global_irq_enable,
    input wire logic fetch_ready,
    input wire logic [24:0] irq_req,
    input wire logic [24:0] irq_enable,
    input wire logic [24:0] irq_ack,
    input rivm_pkg::rivm_fetch_type fetch
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    logic [24:0] pend;
    assign pend = irq_req & irq_enable;
    sequence s_take;
        |irq_ack;
    endsequence
    AST_ONEHOT: assert property ($onehot0(irq_ack)) else $error("ack");
    AST_LOWEST: assert property (s_take |-> (irq_ack & pend) != 0
        && (pend & (irq_ack - 25'h1)) == 0) else $error("lowest");
    AST_GIE: assert property (!global_irq_enable |-> irq_ack == 0)
        else $error("gie");
    AST_BUSY: assert property (fetch.valid |-> irq_ack == 0) else $error("busy");
    AST_ANSWER: assert property (s_take |=> fetch.valid && !fetch.is_reset
        && $past(irq_ack) == 25'h1 << (fetch.vector_num - 5'h2)) else $error("vnum");
    AST_HOLD: assert property (fetch.valid && !fetch_ready |=> $stable(fetch))
        else $error("hold");
    AST_DROP: assert property (fetch.valid && fetch_ready |=> !fetch.valid)
        else $error("drop");
    AST_MAP: assert property (fetch.valid && !fetch.is_reset && !vector_select_bit
        |-> fetch.addr == 15'({fetch.vector_num - 5'h1, 1'b0})) else $error("map");
    AST_RST: assert property ($fell(rst) |=> fetch.valid && fetch.is_reset
        && fetch.vector_num == 5'h1 && (!boot_reset_fuse || fetch.addr == 15'h0))
        else $error("reset");
endmodule // rivm_vector_map_sva

// ---- testbench/rivm_vector_map_tb.sv ----
// Testbench: vector map against a fetching core model
`timescale 1ns/1ps
module rivm_vector_map_tb;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic boot_reset_fuse = 1'h1;
    logic [1:0] boot_size_fuses = 2'h0;
    logic vector_select_bit = 1'h0;
    logic global_irq_enable = 1'h1;
    logic [24:0] irq_req = 25'h0;
    logic [24:0] irq_enable = 25'h1ffffff;
    logic [3:0] stall = 4'h0;
    logic fetch_ready;
    logic [24:0] irq_ack;
    logic [24:0] ack;
    rivm_pkg::rivm_fetch_type fetch;
    rivm_pkg::rivm_fetch_type got;
    logic [14:0] starts [4] = '{rivm_pkg::BOOT_START_0, rivm_pkg::BOOT_START_1,
        rivm_pkg::BOOT_START_2, rivm_pkg::BOOT_START_3};
    int fail_count = 0;
    int num_checks = 0;
    initial forever #12.5 clock = ~clock;
    rivm_vector_map rivm_vector_map_inst (.clock(clock), .rst(rst),
        .boot_reset_fuse(boot_reset_fuse), .boot_size_fuses(boot_size_fuses),
        .vector_select_bit(vector_select_bit), .irq_req(irq_req),
        .irq_enable(irq_enable), .global_irq_enable(global_irq_enable),
        .fetch_ready(fetch_ready), .fetch(fetch), .irq_ack(irq_ack));
    rivm_core_model rivm_core_model_inst (.clock(clock), .rst(rst),
        .fetch(fetch), .stall(stall), .fetch_ready(fetch_ready));
    task conclude;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task check(input logic [24:0] seen, input logic [24:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [24:0] ex(logic r, logic [4:0] v, logic [14:0] a);
        return 25'({1'b1, r, v, a});
    endfunction
    // Waits for a condition a little after each falling edge, bounded
    task take;
        int n;
        for (n = 0; n < 40; n++) begin
            #1;
            if (fetch.valid && fetch_ready) break;
            @(negedge clock);
        end
        if (n == 40) begin
            fail_count++;
            conclude();
        end
        got = fetch;
        @(negedge clock);
    endtask
    task pulse(input logic [24:0] bits);
        int n;
        irq_req = bits;
        for (n = 0; n < 10; n++) begin
            #1;
            if (|irq_ack) break;
            @(negedge clock);
        end
        if (n == 10) begin
            fail_count++;
            conclude();
        end
        ack = irq_ack;
        @(negedge clock);
        irq_req = 25'h0;
    endtask
    task do_reset(input logic fuse, input logic [1:0] sz);
        boot_reset_fuse = fuse;
        boot_size_fuses = sz;
        rst = 1'h1;
        repeat (2) @(negedge clock);
        rst = 1'h0;
        take();
        check(25'(got), ex(1'b1, 5'h1, fuse ? 15'h0 : starts[sz]));
    endtask
    task sweep(input logic vsel);
        vector_select_bit = vsel;
        stall = vsel ? 4'h3 : 4'h0;
        for (int i = 0; i < 25; i++) begin
            pulse(25'h1 << i);
            take();
            check(25'(got), ex(1'b0, 5'(i + 2), 15'(2 * i + 2)
                + (vsel ? starts[boot_size_fuses] : 15'h0)));
        end
    endtask
    task prio;
        vector_select_bit = 1'h0;
        irq_enable = 25'h1fffff7;
        global_irq_enable = 1'h0;
        irq_req = 25'h100408;
        repeat (2) begin
            @(negedge clock);
            check(irq_ack, 25'h0);
        end
        global_irq_enable = 1'h1;
        pulse(25'h100408);
        check(ack, 25'h400);
        take();
        check(25'(got), ex(1'b0, 5'hc, 15'h0016));
    endtask
    initial begin
        for (int s = 0; s < 4; s++) begin
            do_reset(1'b0, 2'(s));
        end
        do_reset(1'b1, 2'h2);
        sweep(1'b0);
        sweep(1'b1);
        prio();
        conclude();
    end
endmodule // rivm_vector_map_tb
bind rivm_vector_map rivm_vector_map_sva rivm_vector_map_sva_inst (
    .clock(clock), .rst(rst), .boot_reset_fuse(boot_reset_fuse),
    .vector_select_bit(vector_select_bit),
    .global_irq_enable(global_irq_enable), .fetch_ready(fetch_ready),
    .irq_req(irq_req), .irq_enable(irq_enable), .irq_ack(irq_ack),
    .fetch(fetch));
